// [logic/triggered_pulse_timer_defs.vh]
// constants for the triggered pulse timer: register offsets, field
// positions, mode codes and reset values.
// assumes byte addresses on an 8-bit APB address, 32-bit data.
`ifndef TRIGGERED_PULSE_TIMER_DEFS_VH
`define TRIGGERED_PULSE_TIMER_DEFS_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define TPT_OFS_CTRL 8'h00
`define TPT_OFS_PERIOD 8'h04
`define TPT_OFS_DUTY 8'h08
`define TPT_OFS_COUNT 8'h0c
`define TPT_OFS_STATUS 8'h10

////////////////////////////////////////////////////////////////////////
// control register fields
`define TPT_CTRL_CE_BIT 0
`define TPT_CTRL_MODE_LSB 1
`define TPT_CTRL_MODE_MSB 3
`define TPT_CTRL_SWTRIG_BIT 4
`define TPT_CTRL_EDGE_LSB 5
`define TPT_CTRL_EDGE_MSB 6

// status register fields
`define TPT_STAT_PERIOD_BIT 0
`define TPT_STAT_DUTY_BIT 1
`define TPT_STAT_RUN_BIT 2
`define TPT_STAT_ARM_BIT 3

////////////////////////////////////////////////////////////////////////
// mode codes
`define TPT_MODE_TRIG_PWM 3'h2
`define TPT_MODE_ONE_SHOT 3'h3

// trigger edge select codes
`define TPT_EDGE_NONE 2'h0
`define TPT_EDGE_RISE 2'h1
`define TPT_EDGE_FALL 2'h2
`define TPT_EDGE_BOTH 2'h3

////////////////////////////////////////////////////////////////////////
// values
`define TPT_CNT_MAX 16'hffff
`define TPT_CNT_ZERO 16'h0000
`define TPT_CNT_ONE 16'h0001
`define TPT_CMP_RESET 16'h0000
`define TPT_MODE_RESET 3'h0
`define TPT_EDGE_RESET 2'h1
`define TPT_DATA_ZERO 32'h0000_0000

`endif

// [logic/triggered_pulse_timer.v]
// triggered pulse timer: one 16-bit channel with triggered pwm and
// one-shot modes, software-visible over an APB slave.
// assumes trigger_input is asynchronous to sys_clk and that software
// keeps the compare write ordering described below.
// the count clock is sys_clk divided by CLK_DIV, one tick per CLK_DIV edges.
//
// Functional notes
// [RL1] mode 010: every trigger zeroes and restarts the counter, output active.
// [RL2] software writes duty compare last; only that write arms the reload.
// [RL3] after a duty write both compare values load into buffers at clear.
// [RL4] period-only change: write period then rewrite duty with same value.
// [RL5] no further compare writes until the period match after a duty write.
// [RL6] duty zero gives 0% output; duty match still fires each cycle.
// [RL7] duty equal period plus one gives 100%; impossible at maximum period.
// [RL8] trigger after duty match: clear, output active, shorter inactive time.
// [RL9] trigger before duty match: no duty irq, output stays active.
// [RL10] trigger after period match: clear and count, active time extended.
// [RL11] trigger before period match: no period irq, clear, output active.
// [RL12] pwm duty match irq fires while count equals duty value.
// [RL13] mode 011: setting count enable waits for a trigger.
// [RL14] one-shot trigger moves counter from maximum to zero, starts pulse.
// [RL15] pulse end parks counter at maximum; triggers during pulse ignored.
// [RL16] one-shot delay is duty counts, width is period minus duty plus one.
// [RL17] one-shot period irq on count after period match; duty irq at equality.
// [RL18] trigger is a valid input edge or a software write of one.
// [RL19] one-shot toggle output active while counting, inactive while waiting.
// [RL20] current count readable at any time.
// [RL21] software stops counting before lowering a compare value.
// [RL22] one-shot compare rewrites act at once; overshoot wraps through zero.
// [RL23] one-shot duty irq coincides with the pulse output transition.
// [RL24] clearing count enable stops counter, both outputs go inactive.
`timescale 1ns/1ps
`default_nettype none
`include "triggered_pulse_timer_defs.vh"

module triggered_pulse_timer #(
  parameter [7:0] CLK_DIV = 8'h01
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // apb slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins
  input wire trigger_input,
  output reg pulse_output,
  output reg toggle_output,
  // match events
  output reg period_match_irq,
  output reg duty_match_irq
);

  ////////////////////////////////////////////////////////////////////////
  // software registers
  reg ce_reg;
  reg ce_prev_reg;
  reg [2:0] mode_reg;
  reg [1:0] edge_sel_reg;
  reg [15:0] period_compare_reg;
  reg [15:0] duty_compare_reg;
  reg period_flag_reg;
  reg duty_flag_reg;

  // channel state
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg run_reg;
  reg run_next;
  reg [15:0] period_buf_reg;
  reg [15:0] period_buf_next;
  reg [15:0] duty_buf_reg;
  reg [15:0] duty_buf_next;
  reg arm_reg;
  reg arm_next;
  reg pulse_next;
  reg toggle_next;
  reg pirq_next;
  reg dirq_next;
  reg cleared;
  reg trig_pend_reg;

  // divider and trigger sync
  // three stages: two against metastability, the third for edge detection
  reg [7:0] div_cnt_reg;
  reg tick_reg;
  reg trig_s1_reg;
  reg trig_s2_reg;
  reg trig_s3_reg;

  // apb decode; pready only gates the first cycle after reset
  wire [7:0] clk_div_m1 = CLK_DIV - 8'h01;
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready;
  wire wr_ctrl = wr_en & (paddr == `TPT_OFS_CTRL);
  wire wr_period = wr_en & (paddr == `TPT_OFS_PERIOD);
  wire wr_duty = wr_en & (paddr == `TPT_OFS_DUTY);
  wire wr_status = wr_en & (paddr == `TPT_OFS_STATUS);

  // codes other than the two pulse modes keep the channel parked
  wire ce_rise = ce_reg & ~ce_prev_reg;
  wire is_pwm = (mode_reg == `TPT_MODE_TRIG_PWM);
  wire is_one = (mode_reg == `TPT_MODE_ONE_SHOT);

  ////////////////////////////////////////////////////////////////////////
  // count clock enable from divider
  // a CLK_DIV of one gives a tick on every edge
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= clk_div_m1) begin
      div_cnt_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger detection; s1 feeds only s2
  wire rise_seen = trig_s2_reg & ~trig_s3_reg;
  wire fall_seen = ~trig_s2_reg & trig_s3_reg;
  reg ext_edge;
  always @* begin
    case (edge_sel_reg)
      `TPT_EDGE_RISE: ext_edge = rise_seen;
      `TPT_EDGE_FALL: ext_edge = fall_seen;
      `TPT_EDGE_BOTH: ext_edge = rise_seen | fall_seen;
      default: ext_edge = 1'b0;
    endcase
  end

  // triggers with count enable low are dropped, not queued
  wire soft_trig = wr_ctrl & pwdata[`TPT_CTRL_SWTRIG_BIT];
  wire new_trig = ce_reg & (ext_edge | soft_trig); // RL18

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trigger_input;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      // held until the next count tick or until count enable drops; a new edge wins over consumption
      if (new_trig)
        trig_pend_reg <= 1'b1;
      else if (tick_reg | ~ce_reg)
        trig_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel next state
  always @* begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    period_buf_next = period_buf_reg;
    duty_buf_next = duty_buf_reg;
    arm_next = arm_reg;
    pulse_next = pulse_output;
    toggle_next = toggle_output;
    pirq_next = 1'b0;
    dirq_next = 1'b0;
    cleared = 1'b0;

    if (!ce_reg) begin
      cnt_next = `TPT_CNT_MAX; // RL24
      run_next = 1'b0;
      pulse_next = 1'b0;
      toggle_next = 1'b0;
    end else if (ce_rise) begin
      // wait for trigger with counter parked
      // buffers take the live compare values so the first cycle is defined
      cnt_next = `TPT_CNT_MAX; // RL13
      run_next = 1'b0;
      period_buf_next = period_compare_reg;
      duty_buf_next = duty_compare_reg;
      arm_next = 1'b0;
      pulse_next = 1'b0;
      toggle_next = 1'b0;
    end else if (is_pwm) begin
      // parked until the first trigger, as in the one-shot mode
      if (tick_reg) begin
        if (trig_pend_reg) begin
          // restart wins over either match, which suppresses its irq
          cnt_next = `TPT_CNT_ZERO; // RL1 RL9 RL11
          run_next = 1'b1;
          cleared = 1'b1;
        end else if (run_reg && cnt_reg == period_buf_reg) begin
          cnt_next = `TPT_CNT_ZERO;
          pirq_next = 1'b1; // RL10
          cleared = 1'b1;
        end else if (run_reg) begin
          cnt_next = cnt_reg + `TPT_CNT_ONE;
        end

        // every clear inverts the toggle pin and applies an armed reload
        if (cleared) begin
          toggle_next = ~toggle_output;
          if (arm_reg) begin
            period_buf_next = period_compare_reg; // RL3
            duty_buf_next = duty_compare_reg;
            arm_next = 1'b0;
          end
        end
        if (run_next) begin
          // active while count below duty: 0% at zero, 100% at period+1
          pulse_next = (cnt_next < duty_buf_next); // RL6 RL7 RL8
          dirq_next = (cnt_next == duty_buf_next); // RL12
        end
      end
    end else if (is_one) begin
      // compare values follow the registers with no staging
      // lowering one while running can overshoot, so software stops first
      period_buf_next = period_compare_reg; // RL22
      duty_buf_next = duty_compare_reg;
      if (tick_reg) begin
        if (!run_reg) begin
          if (trig_pend_reg) begin
            cnt_next = `TPT_CNT_ZERO; // RL14
            run_next = 1'b1;
          end
        end else if (cnt_reg == period_buf_next) begin
          cnt_next = `TPT_CNT_MAX; // RL15
          run_next = 1'b0;
          pirq_next = 1'b1; // RL17
        end else begin
          // plain 16-bit wrap when a lowered compare was overshot
          cnt_next = cnt_reg + `TPT_CNT_ONE; // RL22
        end

        // pulse set at the duty match and held until the stop
        pulse_next = run_next & (pulse_output | (cnt_next == duty_buf_next)); // RL16
        dirq_next = run_next & (cnt_next == duty_buf_next); // RL23
        toggle_next = run_next; // RL19
      end
    end else begin
      cnt_next = `TPT_CNT_MAX;
      run_next = 1'b0;
      pulse_next = 1'b0;
      toggle_next = 1'b0;
    end
  end

  // every output of the channel leaves from this register bank
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= `TPT_CNT_MAX;
      run_reg <= 1'b0;
      period_buf_reg <= `TPT_CMP_RESET;
      duty_buf_reg <= `TPT_CMP_RESET;
      arm_reg <= 1'b0;
      pulse_output <= 1'b0;
      toggle_output <= 1'b0;
      period_match_irq <= 1'b0;
      duty_match_irq <= 1'b0;
      ce_prev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      period_buf_reg <= period_buf_next;
      duty_buf_reg <= duty_buf_next;
      // a duty write in the transfer cycle stays armed
      arm_reg <= arm_next | (wr_duty & ce_reg & is_pwm); // RL2 RL3
      pulse_output <= pulse_next;
      toggle_output <= toggle_next;
      period_match_irq <= pirq_next;
      duty_match_irq <= dirq_next;
      ce_prev_reg <= ce_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_reg <= 1'b0;
      mode_reg <= `TPT_MODE_RESET;
      edge_sel_reg <= `TPT_EDGE_RESET;
      period_compare_reg <= `TPT_CMP_RESET;
      duty_compare_reg <= `TPT_CMP_RESET;
    end else begin
      if (wr_ctrl) begin
        // the soft trigger bit is not stored and reads back as zero
        ce_reg <= pwdata[`TPT_CTRL_CE_BIT];
        mode_reg <= pwdata[`TPT_CTRL_MODE_MSB:`TPT_CTRL_MODE_LSB];
        edge_sel_reg <= pwdata[`TPT_CTRL_EDGE_MSB:`TPT_CTRL_EDGE_LSB];
      end
      if (wr_period)
        period_compare_reg <= pwdata[15:0];
      if (wr_duty)
        duty_compare_reg <= pwdata[15:0];
    end
  end

  // sticky match flags, write one to clear; a new event beats the clear
  // software sees these only through the status word
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_flag_reg <= 1'b0;
      duty_flag_reg <= 1'b0;
    end else begin
      if (pirq_next)
        period_flag_reg <= 1'b1;
      else if (wr_status & pwdata[`TPT_STAT_PERIOD_BIT])
        period_flag_reg <= 1'b0;
      if (dirq_next)
        duty_flag_reg <= 1'b1;
      else if (wr_status & pwdata[`TPT_STAT_DUTY_BIT])
        duty_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read path; data latched in setup, valid through the access cycle
  reg [31:0] rd_mux;
  reg rd_err;

  // count as of the setup cycle, one count older than the access
  always @* begin
    rd_mux = `TPT_DATA_ZERO;
    rd_err = 1'b0;
    case (paddr)
      `TPT_OFS_CTRL: begin
        rd_mux[`TPT_CTRL_CE_BIT] = ce_reg;
        rd_mux[`TPT_CTRL_MODE_MSB:`TPT_CTRL_MODE_LSB] = mode_reg;
        rd_mux[`TPT_CTRL_EDGE_MSB:`TPT_CTRL_EDGE_LSB] = edge_sel_reg;
      end
      `TPT_OFS_PERIOD: rd_mux[15:0] = period_compare_reg;
      `TPT_OFS_DUTY: rd_mux[15:0] = duty_compare_reg;
      `TPT_OFS_COUNT: begin
        rd_mux[15:0] = cnt_reg; // RL20
        rd_err = pwrite;
      end
      `TPT_OFS_STATUS: begin
        rd_mux[`TPT_STAT_PERIOD_BIT] = period_flag_reg;
        rd_mux[`TPT_STAT_DUTY_BIT] = duty_flag_reg;
        rd_mux[`TPT_STAT_RUN_BIT] = run_reg;
        rd_mux[`TPT_STAT_ARM_BIT] = arm_reg;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `TPT_DATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // low only in the first cycle after reset
      pready <= 1'b1;
      if (setup_ph) begin
        prdata <= pwrite ? `TPT_DATA_ZERO : rd_mux;
        pslverr <= rd_err;
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [bench/tpt_monitor.sv]
// port checker for the triggered pulse timer.
// assumes it is bound to triggered_pulse_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "triggered_pulse_timer_defs.vh"
module tpt_monitor (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // apb
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  // pins and events
  input wire pulse_output,
  input wire toggle_output,
  input wire period_match_irq,
  input wire duty_match_irq
);
  reg [2:0] mode_reg;
  reg ce_reg;
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == `TPT_OFS_CTRL;
  // shadow of the control bits, since the checker cannot look inside
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `TPT_MODE_RESET;
      ce_reg <= 1'b0;
    end else if (ctrl_wr) begin
      mode_reg <= pwdata[`TPT_CTRL_MODE_MSB:`TPT_CTRL_MODE_LSB];
      ce_reg <= pwdata[`TPT_CTRL_CE_BIT];
    end
  end
  wire pwm_on = ce_reg && mode_reg == `TPT_MODE_TRIG_PWM;
  wire os_on = ce_reg && mode_reg == `TPT_MODE_ONE_SHOT;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence soft_trig_s;
    ctrl_wr && pwdata[`TPT_CTRL_SWTRIG_BIT];
  endsequence
  sequence os_end_s;
    period_match_irq ##1 !period_match_irq;
  endsequence
  pwm_duty_a: assert property (pwm_on && duty_match_irq |-> !pulse_output)
    else $error("pwm duty event while pulse high");
  os_duty_a: assert property (os_on && duty_match_irq |-> pulse_output)
    else $error("one-shot duty event while pulse low");
  os_rise_a: assert property (os_on && $rose(pulse_output) |-> duty_match_irq)
    else $error("one-shot pulse rose without duty event");
  os_end_a: assert property (os_on && period_match_irq |->
    !pulse_output && !toggle_output && $past(toggle_output))
    else $error("one-shot end did not drop outputs");
  os_park_a: assert property (os_on ##0 os_end_s |-> !toggle_output)
    else $error("one-shot restarted after period event");
  os_start_a: assert property (os_on && !toggle_output ##0 soft_trig_s |-> ##2 toggle_output)
    else $error("one-shot did not start on trigger");
  pwm_restart_a: assert property (pwm_on ##0 soft_trig_s |-> ##2
    (!period_match_irq && toggle_output != $past(toggle_output)))
    else $error("pwm trigger clear wrong");
  stop_idle_a: assert property (!ce_reg [*2] |-> !pulse_output && !toggle_output)
    else $error("outputs active while stopped");
endmodule
`default_nettype wire

// [bench/trigger_source.sv]
// external trigger source: one rising pulse on the trigger pin per request.
// assumes the timer watches rising or falling edges through its synchroniser.
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // request from the bench
  input wire logic fire,
  // pin
  output logic trigger_input
);
  int hold;
  // held several cycles so the synchroniser cannot miss it
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 0;
      trigger_input <= 1'b0;
    end else begin
      hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
      trigger_input <= fire || hold > 1;
    end
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the triggered pulse timer: apb master, count model.
// assumes the defs header is on the include path and CLK_DIV of one.
`timescale 1ns/1ps
`default_nettype none
`include "triggered_pulse_timer_defs.vh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fire = 1'b0;
  logic [31:0] rd, ctl;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, trigger_input, pulse_output, toggle_output;
  wire period_match_irq, duty_match_irq;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int tog_n, pul_n, dirq_n, pirq_n, p, d, t;
  always #25 sys_clk = ~sys_clk;
  triggered_pulse_timer #(.CLK_DIV(8'h01)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_input(trigger_input),
    .pulse_output(pulse_output), .toggle_output(toggle_output),
    .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));
  trigger_source src (.sys_clk(sys_clk), .rst_b(rst_b), .fire(fire),
    .trigger_input(trigger_input));
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; the wait ends only on pready or the global timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic measure(input int n);
    tog_n = 0;
    pul_n = 0;
    dirq_n = 0;
    pirq_n = 0;
    repeat (n) begin
      @(negedge sys_clk);
      tog_n += (toggle_output === 1'b1);
      pul_n += (pulse_output === 1'b1);
      dirq_n += (duty_match_irq === 1'b1);
      pirq_n += (period_match_irq === 1'b1);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(31));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, `TPT_OFS_CTRL, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0020);
    apb(1'b0, `TPT_OFS_COUNT, 32'h0000_0000);
    chk_reg(rd, 32'h0000_ffff);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk_reg({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `TPT_OFS_COUNT, 32'h0000_0005);
    chk_reg({31'h0000_0000, err}, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      p = 6 + $urandom % 25;
      d = 1 + $urandom % p;
      apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0020);
      apb(1'b1, `TPT_OFS_PERIOD, p);
      apb(1'b1, `TPT_OFS_DUTY, d);
      // the second external run watches falling edges instead
      ctl = (k == 3) ? 32'h0000_0047 : 32'h0000_0027;
      apb(1'b1, `TPT_OFS_CTRL, ctl);
      if (k % 2 == 0) begin
        apb(1'b1, `TPT_OFS_CTRL, ctl | 32'h0000_0010);
      end else begin
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
      end
      fork
        measure(p + 16);
        begin
          wait (toggle_output === 1'b1);
          @(posedge sys_clk);
          apb(1'b1, `TPT_OFS_CTRL, ctl | 32'h0000_0010);
        end
      join
      chk_num(tog_n, p + 1);
      chk_num(pul_n, p - d + 1);
      chk_num(dirq_n, 1);
      chk_num(pirq_n, 1);
      apb(1'b0, `TPT_OFS_COUNT, 32'h0000_0000);
      chk_reg(rd, 32'h0000_ffff);
      apb(1'b0, `TPT_OFS_STATUS, 32'h0000_0000);
      chk_reg(rd, 32'h0000_0003);
      apb(1'b1, `TPT_OFS_STATUS, 32'h0000_0003);
    end
    apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0020);
    apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0025);
    apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0035);
    for (int k = 0; k < 6; k++) begin
      p = 3 + $urandom % 18;
      d = (k % 3 == 0) ? 0 : ((k % 3 == 1) ? 1 + $urandom % p : p + 1);
      t = k % 2;
      apb(1'b1, `TPT_OFS_PERIOD, p);
      apb(1'b1, `TPT_OFS_DUTY, d);
      if (t == 1) begin
        apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0035);
        @(posedge sys_clk);
      end else begin
        repeat (2) do @(negedge sys_clk); while (period_match_irq !== 1'b1);
      end
      measure(3 * (p + 1));
      chk_num(pul_n, d * 3);
      chk_num(dirq_n, d <= p ? 3 : 0);
      chk_num(pirq_n, 3 - t);
    end
    apb(1'b1, `TPT_OFS_CTRL, 32'h0000_0020);
    repeat (2) @(posedge sys_clk);
    apb(1'b0, `TPT_OFS_COUNT, 32'h0000_0000);
    chk_reg({rd[29:0], pulse_output, toggle_output}, 32'h0003_fffc);
    results();
  end
endmodule
bind triggered_pulse_timer tpt_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .pulse_output(pulse_output), .toggle_output(toggle_output),
  .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));
`default_nettype wire
